// [servo_io_pkg.sv]
/*
  Shared constants, register map and carrier types of the servo input,
  alarm-clear and gain-group logic.
  Assumes a 200 MHz drive control clock and an AHB-Lite register bus.
*/
// Functional notes
// [RULE1] Setting 3: only an open-to-closed clear edge clears a pending alarm.
// [RULE2] Setting 3: closed-to-open edge or steady level never clears.
// [RULE3] Setting 4: only a closed-to-open clear edge clears a pending alarm.
// [RULE4] Setting 4: open-to-closed edge or steady closed level never clears.
// [RULE5] Outside party idles the clear input at its inactive level.
// [RULE6] A valid clear edge clears pending warnings as well as alarms.
// [RULE7] Without an assigned energize input, the clear input enables the drive.
// [RULE8] Active counterclockwise stop raises negative-limit alarm, blocks negative motion.
// [RULE9] Active clockwise stop raises positive-limit alarm, blocks positive motion.
// [RULE10] Two full seven-gain groups are kept, one active at a time.
// [RULE11] Automatic switching method selector defaults to zero.
// [RULE12] Three switch thresholds: position error 0, velocity 0, torque 10.
// [RULE13] Second-to-first move uses gain2_to_gain1_delay, default 10 ms.
// [RULE14] First-to-second move uses gain1_to_gain2_delay, default 10 ms.
// [RULE15] Reset gains: position 52, velocity 183, integral time 189.
// [RULE16] Reset gains: torque filter 1099, feedforward 10000, filter 20000, derivative 0.
// [RULE17] Methods 1..4 pick group two on error, speed, torque, positioning.
// [RULE18] An assigned gain-pick input alone picks the group.
// [RULE19] Group changes blend gradually over the applicable delay.
// [RULE20] External inputs are synchronised and debounced before edge detection.
// [RULE21] Change completes only if condition holds whole delay, else reverts.
package servo_io_pkg;

  // Clock and timing
  localparam int unsigned CLOCK_PERIOD_PS  = 5000;
  localparam int unsigned DEBOUNCE_TIME_NS = 1000;
  localparam int unsigned DEBOUNCE_CYCLES  = (DEBOUNCE_TIME_NS * 1000) / CLOCK_PERIOD_PS;
  localparam int unsigned MS_IN_PS         = 1000000000;
  localparam int unsigned CYCLES_PER_MS    = MS_IN_PS / CLOCK_PERIOD_PS;
  localparam int unsigned WEIGHT_SHIFT     = 8;
  localparam logic [8:0]  WEIGHT_FULL      = 9'h100;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] POS_THR_OFS = 8'h08;
  localparam logic [7:0] VEL_THR_OFS = 8'h0C;
  localparam logic [7:0] TRQ_THR_OFS = 8'h10;
  localparam logic [7:0] DLY21_OFS   = 8'h14;
  localparam logic [7:0] DLY12_OFS   = 8'h18;
  localparam logic [7:0] GROUP1_OFS  = 8'h20;
  localparam logic [7:0] GROUP2_OFS  = 8'h40;
  localparam int unsigned GAIN_COUNT = 7;

  // Control register fields
  localparam int unsigned CLEAR_OPEN_BIT  = 0;
  localparam int unsigned CW_OPEN_BIT     = 1;
  localparam int unsigned CCW_OPEN_BIT    = 2;
  localparam int unsigned PICK_USED_BIT   = 3;
  localparam int unsigned PICK_OPEN_BIT   = 4;
  localparam int unsigned ENERGIZE_BIT    = 5;
  localparam int unsigned METHOD_LSB      = 8;
  localparam logic [10:0] CTRL_RESET      = 11'h000;

  // Threshold and delay reset values
  localparam logic [31:0] POS_THR_RESET = 32'h0000_0000;
  localparam logic [15:0] VEL_THR_RESET = 16'h0000;
  localparam logic [15:0] TRQ_THR_RESET = 16'h000A;
  localparam logic [15:0] DLY21_RESET   = 16'h000A;
  localparam logic [15:0] DLY12_RESET   = 16'h000A;

  // Automatic switching methods
  typedef enum logic [2:0] {
    METHOD_FIXED = 3'h0,
    METHOD_ERROR = 3'h1,
    METHOD_SPEED = 3'h2,
    METHOD_TORQUE = 3'h3,
    METHOD_POSITIONING = 3'h4
  } gain_method_e;

  // One gain group, first field in the top bits
  typedef struct packed {
    logic [15:0] posGain;
    logic [15:0] derivTime;
    logic [15:0] derivFilter;
    logic [15:0] velFeedfwd;
    logic [15:0] velGain;
    logic [15:0] integTime;
    logic [15:0] torqueFilter;
  } gain_set_s;

  localparam gain_set_s GAIN_RESET = '{
    posGain: 16'h0034, derivTime: 16'h0000, derivFilter: 16'h4E20, velFeedfwd: 16'h2710,
    velGain: 16'h00B7, integTime: 16'h00BD, torqueFilter: 16'h044B};

  // Status word, alarm in bit 0
  typedef struct packed {
    logic driveEnable;
    logic blending;
    logic gainGroup;
    logic negLimit;
    logic posLimit;
    logic warning;
    logic alarm;
  } status_s;

endpackage : servo_io_pkg

// [input_conditioner.sv]
/*
  Synchroniser and debouncer for one asynchronous contact input.
  Assumes the input comes from a pin; level 1 means closed.
*/
`timescale 1ns/1ps
`default_nettype none
module input_conditioner
  import servo_io_pkg::*;
#(
  parameter int unsigned StableCycles = DEBOUNCE_CYCLES
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic        sync1;
  logic        sync2;
  logic        sync3;
  logic [15:0] stableCnt;
  logic        agreed;
  logic        differs;
  logic        settled;

  assign agreed  = (sync2 == sync3);
  assign differs = agreed && (sync3 != level);
  assign settled = differs && (stableCnt >= 16'(StableCycles - 1));

  // Three-stage sync then hold-off before accepting a new level
  always_ff @(posedge clock) begin // [RULE20]
    sync1 <= pin;
    sync2 <= sync1;
    sync3 <= sync2;
    if (srst) begin
      stableCnt <= 16'h0000;
      level     <= 1'b0;
      rise      <= 1'b0;
      fall      <= 1'b0;
    end else begin
      stableCnt <= (differs && !settled) ? stableCnt + 16'h0001 : 16'h0000;
      rise      <= settled && sync3;
      fall      <= settled && !sync3;
      if (settled) begin
        level <= sync3;
      end
    end
  end
endmodule : input_conditioner
`default_nettype wire

// [servo_input_alarm_gain_logic.sv]
/*
  Alarm clear input, travel limits and two-group gain selection of a servo drive,
  with an AHB-Lite register slave.
  Assumes one clock, contact inputs from pins and loop values from same-clock logic.
*/
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module servo_input_alarm_gain_logic
  import servo_io_pkg::*;
#(
  parameter int unsigned CyclesPerMs = CYCLES_PER_MS
) (
  input  wire logic         clock,
  input  wire logic         srst,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  // Contact inputs, 1 means closed
  input  wire logic         faultClearInput,
  input  wire logic         clockwiseTravelStop,
  input  wire logic         counterclockwiseTravelStop,
  input  wire logic         gainGroupPickInput,
  input  wire logic         driveEnergizeInput,
  // Drive events and loop feedback
  input  wire logic         alarmEvent,
  input  wire logic         warningEvent,
  input  wire logic [31:0]  positionError,
  input  wire logic [15:0]  actualVelocity,
  input  wire logic [15:0]  actualTorque,
  input  wire logic         positioningDone,
  // Results
  output status_s           flags,
  output logic              blockPositive,
  output logic              blockNegative,
  output gain_set_s         activeGains
);
  localparam int unsigned NUM_PINS = 5;

  // Magnitude of a two's complement value
  function automatic logic [31:0] magnitude(input logic [31:0] v);
    magnitude = v[31] ? (~v + 32'h0000_0001) : v;
  endfunction : magnitude

  // Weighted mix of two gains, weight out of 256
  function automatic logic [15:0] blend(input logic [15:0] a, input logic [15:0] b,
                                        input logic [8:0] w);
    logic [31:0] mix;
    mix = 32'(a) * (32'(WEIGHT_FULL) - 32'(w)) + 32'(b) * 32'(w);
    blend = 16'(mix >> WEIGHT_SHIFT);
  endfunction : blend

  // Register state
  logic [10:0]  ctrl;
  logic [31:0]  posThreshold;
  logic [15:0]  velThreshold;
  logic [15:0]  trqThreshold;
  logic [15:0]  delay21;
  logic [15:0]  delay12;
  gain_set_s    groups [2];

  // Bus data phase
  logic         dataValid;
  logic         dataWrite;
  logic [7:0]   dataAddr;

  // Conditioned pins
  logic [NUM_PINS-1:0] pinRaw;
  logic [NUM_PINS-1:0] pinLevel;
  logic [NUM_PINS-1:0] pinRise;
  logic [NUM_PINS-1:0] pinFall;

  // Alarm and blend state
  logic         alarmPending;
  logic         warningPending;
  logic         gainGroup;
  logic [8:0]   weight;
  logic [39:0]  stepCnt;

  assign pinRaw = {driveEnergizeInput, gainGroupPickInput, counterclockwiseTravelStop,
                   clockwiseTravelStop, faultClearInput};

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    input_conditioner #(
      .StableCycles (DEBOUNCE_CYCLES)
    ) u_cond (
      .clock (clock),
      .srst  (srst),
      .pin   (pinRaw[i]),
      .level (pinLevel[i]),
      .rise  (pinRise[i]),
      .fall  (pinFall[i])
    );
  end

  // Bus address decode
  wire          addrPhase = hsel && htrans[1] && hready;
  wire          wrPhase   = dataValid && dataWrite;
  wire [2:0]    gainIdx   = 3'(dataAddr[4:2]);
  wire          wrCtrl    = wrPhase && (dataAddr == CTRL_OFS);
  wire          wrPos     = wrPhase && (dataAddr == POS_THR_OFS);
  wire          wrVel     = wrPhase && (dataAddr == VEL_THR_OFS);
  wire          wrTrq     = wrPhase && (dataAddr == TRQ_THR_OFS);
  wire          wrDly21   = wrPhase && (dataAddr == DLY21_OFS);
  wire          wrDly12   = wrPhase && (dataAddr == DLY12_OFS);
  wire          inGroup1  = (dataAddr[7:5] == GROUP1_OFS[7:5]) && (gainIdx < 3'(GAIN_COUNT));
  wire          inGroup2  = (dataAddr[7:5] == GROUP2_OFS[7:5]) && (gainIdx < 3'(GAIN_COUNT));
  wire [6:0]    fieldLsb  = 7'((GAIN_COUNT - 1 - 32'(gainIdx)) * 16);

  // Pin meanings after polarity selection
  wire          clearOpenMode = ctrl[CLEAR_OPEN_BIT];
  wire          clearEdge     = clearOpenMode ? pinFall[0] : pinRise[0]; // [RULE1] [RULE2] [RULE3] [RULE4]
  wire          clearActive   = pinLevel[0] ^ clearOpenMode; // [RULE5]
  wire          cwActive      = pinLevel[1] ^ ctrl[CW_OPEN_BIT]; // [RULE9]
  wire          ccwActive     = pinLevel[2] ^ ctrl[CCW_OPEN_BIT]; // [RULE8]
  wire          pickActive    = pinLevel[3] ^ ctrl[PICK_OPEN_BIT];
  wire          energizeOn    = ctrl[ENERGIZE_BIT] ? pinLevel[4] : clearActive; // [RULE7]

  // Automatic switching condition
  gain_method_e method;
  logic         autoSecond;
  assign method = gain_method_e'(ctrl[METHOD_LSB +: 3]);

  always_comb begin
    unique case (method) // [RULE17]
      METHOD_FIXED:       autoSecond = 1'b0;
      METHOD_ERROR:       autoSecond = magnitude(positionError) >= posThreshold;
      METHOD_SPEED:       autoSecond = magnitude({{16{actualVelocity[15]}}, actualVelocity}) >= 32'(velThreshold);
      METHOD_TORQUE:      autoSecond = magnitude({{16{actualTorque[15]}}, actualTorque}) >= 32'(trqThreshold);
      METHOD_POSITIONING: autoSecond = !positioningDone;
      default:            autoSecond = 1'b0;
    endcase
  end

  // Target group and blend stepping
  wire          wantSecond = ctrl[PICK_USED_BIT] ? pickActive : autoSecond; // [RULE18]
  wire [15:0]   delayMs    = wantSecond ? delay12 : delay21; // [RULE13] [RULE14]
  wire [39:0]   stepPeriod = (40'(delayMs) * 40'(CyclesPerMs)) >> WEIGHT_SHIFT;
  wire          atTarget   = wantSecond ? (weight == WEIGHT_FULL) : (weight == 9'h000);
  wire          stepNow    = !atTarget && (stepPeriod == 40'h00_0000_0000 ||
                                           stepCnt >= stepPeriod - 40'h00_0000_0001);
  wire [8:0]    nextWeight = (delayMs == 16'h0000) ? (wantSecond ? WEIGHT_FULL : 9'h000)
                                                   : (wantSecond ? weight + 9'h001 : weight - 9'h001);

  // Bus pipeline
  always_ff @(posedge clock) begin
    if (srst) begin
      dataValid <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr  <= 8'h00;
    end else if (hready) begin
      dataValid <= addrPhase;
      dataWrite <= hwrite;
      dataAddr  <= haddr[7:0];
    end
  end

  // Settings registers
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl         <= CTRL_RESET; // [RULE11]
      posThreshold <= POS_THR_RESET; // [RULE12]
      velThreshold <= VEL_THR_RESET;
      trqThreshold <= TRQ_THR_RESET;
      delay21      <= DLY21_RESET;
      delay12      <= DLY12_RESET;
    end else begin
      if (wrCtrl) ctrl <= hwdata[10:0];
      if (wrPos) posThreshold <= hwdata;
      if (wrVel) velThreshold <= hwdata[15:0];
      if (wrTrq) trqThreshold <= hwdata[15:0];
      if (wrDly21) delay21 <= hwdata[15:0];
      if (wrDly12) delay12 <= hwdata[15:0];
    end
  end

  // Two gain groups
  always_ff @(posedge clock) begin
    if (srst) begin
      groups[0] <= GAIN_RESET; // [RULE10] [RULE15] [RULE16]
      groups[1] <= GAIN_RESET;
    end else if (wrPhase && inGroup1) begin
      groups[0][fieldLsb +: 16] <= hwdata[15:0];
    end else if (wrPhase && inGroup2) begin
      groups[1][fieldLsb +: 16] <= hwdata[15:0];
    end
  end

  // Pending alarm and warning, new event wins over clear
  always_ff @(posedge clock) begin
    if (srst) begin
      alarmPending   <= 1'b0;
      warningPending <= 1'b0;
    end else begin
      alarmPending   <= alarmEvent || (alarmPending && !clearEdge); // [RULE1] [RULE3]
      warningPending <= warningEvent || (warningPending && !clearEdge); // [RULE6]
    end
  end

  // Gradual group change, reverses if the condition lapses
  always_ff @(posedge clock) begin
    if (srst) begin
      weight    <= 9'h000;
      stepCnt   <= 40'h00_0000_0000;
      gainGroup <= 1'b0;
    end else begin
      if (atTarget || stepNow) begin
        stepCnt <= 40'h00_0000_0000;
      end else begin
        stepCnt <= stepCnt + 40'h00_0000_0001;
      end
      if (stepNow) begin
        weight <= nextWeight; // [RULE19]
      end
      if (weight == WEIGHT_FULL) begin
        gainGroup <= 1'b1; // [RULE21]
      end else if (weight == 9'h000) begin
        gainGroup <= 1'b0;
      end
    end
  end

  // Blended gains out
  always_ff @(posedge clock) begin
    if (srst) begin
      activeGains <= GAIN_RESET;
    end else begin
      for (int k = 0; k < GAIN_COUNT; k++) begin
        activeGains[k*16 +: 16] <= blend(groups[0][k*16 +: 16], groups[1][k*16 +: 16], weight);
      end
    end
  end

  // Limit and status outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      flags         <= '0;
      blockPositive <= 1'b0;
      blockNegative <= 1'b0;
    end else begin
      flags.alarm       <= alarmPending;
      flags.warning     <= warningPending;
      flags.posLimit    <= cwActive; // [RULE9]
      flags.negLimit    <= ccwActive; // [RULE8]
      flags.gainGroup   <= gainGroup;
      flags.blending    <= (weight != 9'h000) && (weight != WEIGHT_FULL);
      flags.driveEnable <= energizeOn && !alarmPending; // [RULE7]
      blockPositive     <= cwActive; // [RULE9]
      blockNegative     <= ccwActive; // [RULE8]
    end
  end

  // Read mux, data phase
  logic [31:0] readData;
  always_comb begin
    readData = 32'h0000_0000;
    if (inGroup1) begin
      readData = {16'h0000, groups[0][fieldLsb +: 16]};
    end else if (inGroup2) begin
      readData = {16'h0000, groups[1][fieldLsb +: 16]};
    end else begin
      unique case (dataAddr)
        CTRL_OFS:    readData = {21'h00_0000, ctrl};
        STATUS_OFS:  readData = {25'h000_0000, flags};
        POS_THR_OFS: readData = posThreshold;
        VEL_THR_OFS: readData = {16'h0000, velThreshold};
        TRQ_THR_OFS: readData = {16'h0000, trqThreshold};
        DLY21_OFS:   readData = {16'h0000, delay21};
        DLY12_OFS:   readData = {16'h0000, delay12};
        default:     readData = 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = (dataValid && !dataWrite) ? readData : 32'h0000_0000;

endmodule : servo_input_alarm_gain_logic
`default_nettype wire

// [contact_bank.sv]
/*
  Contact model: limit switches and host outputs on the five contact pins.
  Assumes the bench asks for levels just after a clock edge; 1 means closed.
*/
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
  input  wire logic       clock,
  input  wire logic [4:0] want,
  output logic      [4:0] pins
);
  logic [4:0] held;
  logic [4:0] moving;
  int         chatter;

  initial begin
    held    = 5'h00;
    moving  = 5'h00;
    chatter = 0;
    pins    = 5'h00;
  end

  // Moved contacts chatter for 30 cycles, then rest at the asked level
  always @(posedge clock) begin
    if (want != held) begin
      held    <= want;
      moving  <= want ^ held;
      chatter <= 30;
    end else if (chatter > 0) begin
      chatter <= chatter - 1;
    end
    pins <= held ^ ((chatter > 0 && chatter % 4 < 2) ? moving : 5'h00);
  end
endmodule : contact_bank
`default_nettype wire

// [servo_alarm_gain_asserts.sv]
/*
  Port checker of the servo input, alarm-clear and gain logic.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_alarm_gain_asserts
  import servo_io_pkg::*;
#(
  parameter int unsigned CyclesPerMs = CYCLES_PER_MS
) (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        faultClearInput,
  input wire logic        alarmEvent,
  input wire logic        warningEvent,
  input wire status_s     flags,
  input wire logic        blockPositive,
  input wire logic        blockNegative
);
  logic       rdPhase;
  logic       prevClear;
  logic [9:0] clearQuiet;

  // Read data phase, cycles since the clear pin last moved
  always_ff @(posedge clock) begin
    if (srst) begin
      rdPhase    <= 1'b0;
      prevClear  <= faultClearInput;
      clearQuiet <= 10'h3FF;
    end else begin
      rdPhase    <= hsel && htrans[1] && hready && !hwrite;
      prevClear  <= faultClearInput;
      clearQuiet <= (faultClearInput != prevClear) ? 10'h000 : clearQuiet + {9'h000, clearQuiet != 10'h3FF};
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  sequence clearSettled;
    clearQuiet >= 10'h0C3 && clearQuiet <= 10'h0D7;
  endsequence

  a_bus_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_idle_read_zero: assert property (!rdPhase |-> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");
  a_alarm_event_set: assert property (alarmEvent |-> ##2 flags.alarm)
    else $error("alarm event not shown");
  a_warn_event_set: assert property (warningEvent |-> ##2 flags.warning)
    else $error("warning event not shown");
  a_alarm_clear_edge: assert property ($fell(flags.alarm) |-> clearSettled)
    else $error("alarm cleared without a settled clear edge");
  a_warn_clear_edge: assert property ($fell(flags.warning) |-> clearSettled)
    else $error("warning cleared without a settled clear edge");
  a_pos_limit_flag: assert property ($rose(blockPositive) |-> ##[0:1] flags.posLimit)
    else $error("positive block without positive limit alarm");
  a_neg_limit_flag: assert property ($rose(blockNegative) |-> ##[0:1] flags.negLimit)
    else $error("negative block without negative limit alarm");
  a_alarm_stops_drive: assert property (flags.alarm [*2] |-> !flags.driveEnable)
    else $error("drive enabled with an alarm pending");
  a_group_after_blend: assert property ($changed(flags.gainGroup) |->
      $past(flags.blending) || $past(flags.blending, 2) || $past(flags.blending, 3))
    else $error("gain group changed without a blend");
endmodule : servo_alarm_gain_asserts

bind servo_input_alarm_gain_logic servo_alarm_gain_asserts #(
  .CyclesPerMs(CyclesPerMs)
) i_servo_alarm_gain_asserts (
  .clock(clock), .srst(srst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .faultClearInput(faultClearInput),
  .alarmEvent(alarmEvent), .warningEvent(warningEvent), .flags(flags),
  .blockPositive(blockPositive), .blockNegative(blockNegative)
);
`default_nettype wire

// [tb_top.sv]
/*
  Self-checking bench of the servo input, alarm-clear and gain logic.
  Assumes the contact model drives the pins and the bench is the bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import servo_io_pkg::*;
;
  localparam int unsigned CPM       = 256;
  localparam int          DFLT[7]   = '{52, 0, 20000, 10000, 183, 189, 1099};
  localparam logic [7:0]  RADDR[7]  = '{CTRL_OFS, POS_THR_OFS, VEL_THR_OFS, TRQ_THR_OFS, DLY21_OFS, DLY12_OFS, 8'h1C};
  localparam int          REXP[7]   = '{0, 0, 0, 10, 10, 10, 0};
  localparam logic [3:0]  NEWPIN    = 4'h5;
  localparam logic [3:0]  CLEARS    = 4'h9;
  logic        clock, srst, hsel, hwrite, hreadyout, hresp, alarmEvent, warningEvent, positioningDone;
  logic        blockPositive, blockNegative;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  want, pins;
  logic [15:0] actualVelocity, actualTorque;
  logic [31:0] haddr, hwdata, hrdata, positionError, rd;
  status_s     flags;
  gain_set_s   activeGains;
  int          fail_count, checked, seed, ctrl, alarmM, warnM, grp, thr, n, flips;
  int          g1[7], g2[7];

  servo_input_alarm_gain_logic #(.CyclesPerMs(CPM)) i_servo_input_alarm_gain_logic (
    .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .faultClearInput(pins[0]), .clockwiseTravelStop(pins[1]), .counterclockwiseTravelStop(pins[2]),
    .gainGroupPickInput(pins[3]), .driveEnergizeInput(pins[4]), .alarmEvent(alarmEvent),
    .warningEvent(warningEvent), .positionError(positionError), .actualVelocity(actualVelocity),
    .actualTorque(actualTorque), .positioningDone(positioningDone), .flags(flags),
    .blockPositive(blockPositive), .blockNegative(blockNegative), .activeGains(activeGains));

  contact_bank i_contact_bank (.clock(clock), .want(want), .pins(pins));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic report(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : report

  task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
    report({96'h0, got}, {96'h0, exp});
  endtask : cmpReg

  // Model of flags, blocks and gains
  task automatic cmpState;
    logic      ca;
    status_s   f;
    gain_set_s gs;
    ca = ctrl[0] ? !want[0] : want[0];
    f  = {(ctrl[5] ? want[4] : ca) && alarmM == 0, 1'b0, grp[0], want[2] ^ ctrl[2], want[1] ^ ctrl[1], warnM[0], alarmM[0]};
    for (int i = 0; i < 7; i++) gs[111 - 16 * i -: 16] = grp[0] ? g2[i][15:0] : g1[i][15:0];
    report({7'h0, flags, blockPositive, blockNegative, activeGains}, {7'h0, f, f.posLimit, f.negLimit, gs});
  endtask : cmpState

  task automatic waitCyc(input int c);
    repeat (c) @(posedge clock);
  endtask : waitCyc

  task automatic hold;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      summarize;
    end
  endtask : hold

  task automatic bus(input logic wrt, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wrt;
    haddr  <= {24'h00_0000, a};
    hsize  <= 3'h2;
    hold;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    hold;
    rd = hrdata;
  endtask : bus

  task automatic fault;
    alarmEvent   <= 1'b1;
    warningEvent <= 1'b1;
    @(posedge clock);
    alarmEvent   <= 1'b0;
    warningEvent <= 1'b0;
    waitCyc(3);
    alarmM = 1;
    warnM  = 1;
  endtask : fault

  task automatic waitGroup(input logic g);
    n = 0;
    while (flags.gainGroup !== g && n < 1500) begin
      @(posedge clock);
      n++;
    end
    if (n >= 1500) begin
      fail_count++;
      summarize;
    end
    grp = g;
    waitCyc(3);
  endtask : waitGroup

  task automatic cond(input int m, input logic on);
    positionError   <= 32'((on && m < 2) ? -thr : thr - 1);
    actualVelocity  <= 16'((on && (m == 0 || m == 2)) ? -thr : thr - 1);
    actualTorque    <= 16'((on && (m == 0 || m == 3)) ? -thr : thr - 1);
    positioningDone <= !(on && (m == 0 || m == 4));
  endtask : cond

  initial begin
    {srst, hsel, hwrite, alarmEvent, warningEvent, positioningDone} = 6'h21;
    {htrans, hsize, haddr, hwdata, positionError, actualVelocity, actualTorque, want} = '0;
    {fail_count, checked, ctrl, alarmM, warnM, grp, thr} = '0;
    seed = 32'haf63a7d6;
    waitCyc(10);
    srst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 7; i++) begin
      g1[i] = DFLT[i];
      g2[i] = DFLT[i];
      bus(1'b0, GROUP1_OFS + 8'(4 * i), 32'h0);
      cmpReg(rd, 32'(DFLT[i]));
      bus(1'b0, GROUP2_OFS + 8'(4 * i), 32'h0);
      cmpReg(rd, 32'(DFLT[i]));
    end
    cmpState;
    bus(1'b1, 8'h1C, 32'($random(seed)));
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, RADDR[i], 32'h0);
      cmpReg(rd, 32'(REXP[i]));
    end
    for (int k = 0; k < 4; k++) begin
      ctrl = k / 2;
      bus(1'b1, CTRL_OFS, 32'(ctrl));
      fault;
      cmpState;
      bus(1'b0, STATUS_OFS, 32'h0);
      cmpReg(rd, 32'h0000_0003);
      want[0] <= NEWPIN[k];
      waitCyc(260);
      if (CLEARS[k]) {alarmM, warnM} = '0;
      cmpState;
    end
    for (int k = 0; k < 4; k++) begin
      ctrl = (k % 2) * 34 + (k / 2) * 4;
      bus(1'b1, CTRL_OFS, 32'(ctrl));
      want <= {k[1], 1'b0, k[0], k[1], 1'b0};
      waitCyc(260);
      cmpState;
    end
    for (int i = 0; i < 7; i++) begin
      g1[i] = $random(seed) & 32'h0000_FFFF;
      g2[i] = $random(seed) & 32'h0000_FFFF;
      bus(1'b1, GROUP1_OFS + 8'(4 * i), 32'(g1[i]));
      bus(1'b1, GROUP2_OFS + 8'(4 * i), 32'(g2[i]));
    end
    thr = ($random(seed) & 32'h0000_3FFF) + 1;
    bus(1'b1, DLY21_OFS, 32'h0000_0001);
    bus(1'b1, DLY12_OFS, 32'h0000_0002);
    bus(1'b1, POS_THR_OFS, 32'(thr));
    bus(1'b1, VEL_THR_OFS, 32'(thr));
    bus(1'b1, TRQ_THR_OFS, 32'(thr));
    ctrl = 0;
    bus(1'b1, CTRL_OFS, 32'h0);
    want <= 5'h00;
    cond(0, 1'b0);
    waitCyc(260);
    cmpState;
    for (int m = 0; m < 5; m++) begin
      ctrl = m * 256;
      bus(1'b1, CTRL_OFS, 32'(ctrl));
      cond(m, 1'b1);
      waitCyc(100);
      if (m == 0) begin
        waitCyc(600);
        cmpState;
      end else begin
        cmpReg({31'h0, flags.blending}, 32'h1);
        waitGroup(1'b1);
        cmpReg(32'(n >= 400 && n <= 430), 32'h1);
        cmpState;
        cond(m, 1'b0);
        waitGroup(1'b0);
        cmpReg(32'(n >= 250 && n <= 275), 32'h1);
        cmpState;
      end
    end
    ctrl = 256;
    bus(1'b1, CTRL_OFS, 32'(ctrl));
    cond(1, 1'b1);
    waitCyc(100);
    cond(1, 1'b0);
    flips = 0;
    repeat (600) begin
      @(posedge clock);
      if (flags.gainGroup !== 1'b0) flips++;
    end
    cmpReg(32'(flips), 32'h0);
    cmpState;
    ctrl = 264;
    bus(1'b1, CTRL_OFS, 32'(ctrl));
    cond(1, 1'b1);
    waitCyc(700);
    cmpState;
    want <= 5'h08;
    waitGroup(1'b1);
    cmpState;
    ctrl = 280;
    bus(1'b1, CTRL_OFS, 32'(ctrl));
    waitGroup(1'b0);
    cmpState;
    srst <= 1'b1;
    waitCyc(2);
    srst <= 1'b0;
    {ctrl, grp} = '0;
    for (int i = 0; i < 7; i++) g1[i] = DFLT[i];
    waitCyc(3);
    cmpState;
    bus(1'b0, CTRL_OFS, 32'h0);
    cmpReg(rd, 32'h0000_0000);
    summarize;
  end
endmodule : tb_top
`default_nettype wire
